// ===== core/panel_clock_pins.sv
// Clock selection, panel interface and power-down pin logic of the display controller.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Strap pin during reset picks clock mode.
// - Multi-input mode selects one of four sources.
// - External mode frequency from misc select bits.
// - Option bit forces memory clock as shift.
// - Single select: second pin gives load strobe.
// - Dual select: second/third pins drive select.
// - Single select: third pin follows select bit.
// - Memory clock times access, may shift video.
// - Panel enable output switches panel supply.
// - Function bit picks bias-off or palette strobe.
// - Bias-off high removes power, sequenced except in power-down.
// - Pixel data changes on pixel clock rise.
// - LCD: frame-rate clock; otherwise blanking signal.
// - Upper data per LCD, plasma, CRT mode.
// - Lower data per mode, zero in plasma.
// - Shift clock moves dual-panel column data.
// - Weight clock in LCD, video enable plasma.
// - Frame pulse at each new frame.
// - Latch pulse loads the scan line.
// - Power-down halts timing, blanks, panels off.
// - Registers stay reachable during power-down.
module panel_clock_pins
	import panel_pins_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [7:0] reg_rdata_o,
	input wire logic memory_data_bit3_strap_i,
	input wire logic primary_video_clock_i,
	input wire logic second_video_clock_i,
	output logic second_video_clock_o,
	output logic second_video_clock_oe_n_o,
	input wire logic third_video_clock_i,
	output logic third_video_clock_o,
	output logic third_video_clock_oe_n_o,
	input wire logic power_down_in_n_i,
	input wire logic [7:0] pixel_data_i,
	output logic pixel_take_o,
	output logic panel_power_enable_o,
	output logic bias_off_or_palette_write_o,
	output logic pixel_clock_o,
	output logic frame_rate_or_blank_o,
	output logic [3:0] upper_panel_data_o,
	output logic [3:0] lower_panel_data_o,
	output logic column_driver_shift_clock_o,
	output logic gray_weight_clock_o,
	output logic frame_start_pulse_o,
	output logic line_latch_pulse_o,
	output logic dac_enable_o
);
	localparam logic [15:0] SEQ_LAST = 16'(PANEL_SEQ_CYCLES - 1);
	localparam logic [3:0] LOAD_LEN = 4'(LOAD_STROBE_CYCLES);
	localparam logic [3:0] PAL_LEN = 4'(PAL_STROBE_CYCLES);

	edge_if primary_sync ();
	edge_if second_sync ();
	edge_if third_sync ();
	edge_if pd_sync ();

	logic strap_meta;
	logic strap_stable;
	logic external_mode;
	logic [7:0] clock_select_register;
	logic [7:0] clock_option_register;
	logic [7:0] panel_pin_function_register;
	logic [7:0] misc_clock_register;
	logic [7:0] mode_register;
	logic [7:0] frame_rate_divider;
	logic [1:0] mode;
	logic power_down;
	logic dual_select;
	logic shift_en;
	logic pixel_step;
	logic pixel_clock;
	logic [9:0] hcount;
	logic [9:0] vcount;
	logic active;
	logic active_q;
	logic weight_toggle;
	logic [7:0] fr_count;
	logic frame_rate_clock;
	logic [3:0] load_count;
	logic [3:0] pal_count;
	logic palette_write_strobe_n;
	logic panel_bias_power_off;
	seq_state_t seq_state;
	logic [15:0] seq_count;
	logic panel_request;

	pin_sync #(.INIT(1'b0)) primary_sync_u (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.async_i(primary_video_clock_i),
		.sync(primary_sync)
	);
	pin_sync #(.INIT(1'b0)) second_sync_u (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.async_i(second_video_clock_i),
		.sync(second_sync)
	);
	pin_sync #(.INIT(1'b0)) third_sync_u (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.async_i(third_video_clock_i),
		.sync(third_sync)
	);
	// Idle level is high so a reset does not look like a power-down request.
	pin_sync #(.INIT(1'b1)) pd_sync_u (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.async_i(power_down_in_n_i),
		.sync(pd_sync)
	);

	assign power_down = ~pd_sync.level;
	assign mode = mode_register[1:0];
	assign dual_select = clock_option_register[DUAL_SEL_BIT];

	// The strap is caught while reset is held, so these flops carry no reset.
	always_ff @(posedge clk_i) begin
		strap_meta <= memory_data_bit3_strap_i;
		strap_stable <= strap_meta;
		if (reset_i) begin
			external_mode <= strap_stable;
		end
	end

	// Register file; writes are accepted in power-down as well.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			clock_select_register <= CLK_SEL_RESET;
			clock_option_register <= CLK_OPT_RESET;
			panel_pin_function_register <= PIN_FUNC_RESET;
			misc_clock_register <= MISC_CLK_RESET;
			mode_register <= MODE_RESET;
			frame_rate_divider <= FR_DIV_RESET;
		end else if (reg_write_i) begin
			case (reg_addr_i)
				CLK_SEL_ADDR: clock_select_register <= reg_wdata_i;
				CLK_OPT_ADDR: clock_option_register <= reg_wdata_i;
				PIN_FUNC_ADDR: panel_pin_function_register <= reg_wdata_i;
				MISC_CLK_ADDR: misc_clock_register <= reg_wdata_i;
				MODE_ADDR: mode_register <= reg_wdata_i;
				FR_DIV_ADDR: frame_rate_divider <= reg_wdata_i;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_read_i) begin
			case (reg_addr_i)
				CLK_SEL_ADDR: reg_rdata_o <= clock_select_register;
				CLK_OPT_ADDR: reg_rdata_o <= clock_option_register;
				PIN_FUNC_ADDR: reg_rdata_o <= panel_pin_function_register;
				MISC_CLK_ADDR: reg_rdata_o <= misc_clock_register;
				MODE_ADDR: reg_rdata_o <= mode_register;
				FR_DIV_ADDR: reg_rdata_o <= frame_rate_divider;
				STATUS_ADDR: begin
					reg_rdata_o <= 8'h00;
					reg_rdata_o[ST_EXT_MODE_BIT] <= external_mode;
					reg_rdata_o[ST_POWER_DOWN_BIT] <= power_down;
					reg_rdata_o[ST_PANEL_EN_BIT] <= panel_power_enable_o;
					reg_rdata_o[ST_BIAS_ON_BIT] <= ~panel_bias_power_off;
				end
				default: reg_rdata_o <= 8'h00;
			endcase
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end

	// Shift clock enable. The memory clock is clk_i itself, so choosing it gives an
	// enable on every cycle.
	always_comb begin
		shift_en = 1'b0;
		if (clock_option_register[MCLK_SHIFT_BIT]) begin
			shift_en = 1'b1;
		end else if (external_mode) begin
			shift_en = primary_sync.rise;
		end else begin
			case (clock_select_register[VSRC_LSB +: 2])
				VSRC_PRIMARY: shift_en = primary_sync.rise;
				VSRC_SECOND: shift_en = second_sync.rise;
				VSRC_THIRD: shift_en = third_sync.rise;
				default: shift_en = 1'b1;
			endcase
		end
	end

	// Second and third clock pins turn into outputs in external-clock mode.
	always_comb begin
		second_video_clock_oe_n_o = ~external_mode;
		third_video_clock_oe_n_o = ~external_mode;
		if (dual_select) begin
			second_video_clock_o = misc_clock_register[SEL_LOW_BIT];
			third_video_clock_o = misc_clock_register[SEL_HIGH_BIT];
		end else begin
			second_video_clock_o = load_count != 4'h0;
			third_video_clock_o = clock_select_register[SINGLE_SEL_BIT];
		end
	end

	// Load strobe follows each write of the frequency select bits in external single-select mode.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			load_count <= 4'h0;
		end else if (reg_write_i && reg_addr_i == MISC_CLK_ADDR && external_mode && !dual_select) begin
			load_count <= LOAD_LEN;
		end else if (load_count != 4'h0) begin
			load_count <= load_count - 4'h1;
		end
	end

	// Active-low palette write pulse, started by a write to its strobe address.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pal_count <= 4'h0;
		end else if (reg_write_i && reg_addr_i == PAL_STROBE_ADDR) begin
			pal_count <= PAL_LEN;
		end else if (pal_count != 4'h0) begin
			pal_count <= pal_count - 4'h1;
		end
	end
	assign palette_write_strobe_n = pal_count == 4'h0;

	// Pixel clock runs at half the shift rate; data moves with its rising edge.
	assign pixel_step = shift_en & ~pixel_clock & ~power_down;
	assign active = hcount < H_ACTIVE && vcount < V_ACTIVE;
	assign pixel_take_o = pixel_step & active;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pixel_clock <= 1'b0;
		end else if (power_down) begin
			pixel_clock <= 1'b0;
		end else if (shift_en) begin
			pixel_clock <= ~pixel_clock;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			hcount <= 10'd0;
			vcount <= 10'd0;
		end else if (pixel_step) begin
			if (hcount == H_TOTAL - 10'd1) begin
				hcount <= 10'd0;
				vcount <= (vcount == V_TOTAL - 10'd1) ? 10'd0 : vcount + 10'd1;
			end else begin
				hcount <= hcount + 10'd1;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			upper_panel_data_o <= 4'h0;
			lower_panel_data_o <= 4'h0;
			active_q <= 1'b0;
		end else if (power_down) begin
			upper_panel_data_o <= 4'h0;
			lower_panel_data_o <= 4'h0;
			active_q <= 1'b0;
		end else if (pixel_step) begin
			upper_panel_data_o <= active ? pixel_data_i[7:4] : 4'h0;
			if (mode == MODE_PLASMA) begin
				lower_panel_data_o <= 4'h0;
			end else begin
				lower_panel_data_o <= active ? pixel_data_i[3:0] : 4'h0;
			end
			active_q <= active;
		end
	end

	// Panel strobes update on pixel steps; power-down clears the latch and frame pulses and freezes the weight toggle.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			line_latch_pulse_o <= 1'b0;
			frame_start_pulse_o <= 1'b0;
			weight_toggle <= 1'b0;
		end else if (power_down) begin
			line_latch_pulse_o <= 1'b0;
			frame_start_pulse_o <= 1'b0;
		end else if (pixel_step && mode != MODE_CRT) begin
			line_latch_pulse_o <= hcount == H_ACTIVE;
			frame_start_pulse_o <= vcount == 10'd0 && hcount >= H_ACTIVE;
			if (hcount == H_ACTIVE) begin
				weight_toggle <= ~weight_toggle;
			end
		end else if (mode == MODE_CRT) begin
			line_latch_pulse_o <= 1'b0;
			frame_start_pulse_o <= 1'b0;
		end
	end

	always_comb begin
		column_driver_shift_clock_o = 1'b0;
		gray_weight_clock_o = 1'b0;
		case (mode)
			MODE_LCD: begin
				column_driver_shift_clock_o = pixel_clock & active_q;
				gray_weight_clock_o = weight_toggle;
			end
			MODE_PLASMA: gray_weight_clock_o = active_q;
			default: ;
		endcase
	end

	// Frame-rate clock free-runs on the system clock and stops only in power-down.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			fr_count <= 8'h00;
			frame_rate_clock <= 1'b0;
		end else if (!power_down) begin
			if (fr_count >= frame_rate_divider) begin
				fr_count <= 8'h00;
				frame_rate_clock <= ~frame_rate_clock;
			end else begin
				fr_count <= fr_count + 8'h01;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			frame_rate_or_blank_o <= 1'b1;
		end else if (mode == MODE_LCD) begin
			frame_rate_or_blank_o <= frame_rate_clock;
		end else begin
			frame_rate_or_blank_o <= power_down | ~active_q;
		end
	end

	// Power sequencing: logic supply first, bias last; reverse when the panel-on bit clears, both off at once in power-down.
	assign panel_request = panel_pin_function_register[PANEL_ON_BIT] & ~power_down;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			seq_state <= SEQ_OFF;
			seq_count <= 16'h0000;
		end else if (power_down) begin
			seq_state <= SEQ_OFF;
			seq_count <= 16'h0000;
		end else begin
			case (seq_state)
				SEQ_OFF: begin
					seq_count <= 16'h0000;
					if (panel_request) begin
						seq_state <= SEQ_LOGIC;
					end
				end
				SEQ_LOGIC: begin
					if (!panel_request) begin
						seq_state <= SEQ_OFF;
					end else if (seq_count == SEQ_LAST) begin
						seq_state <= SEQ_ON;
					end else begin
						seq_count <= seq_count + 16'h0001;
					end
				end
				SEQ_ON: begin
					seq_count <= 16'h0000;
					if (!panel_request) begin
						seq_state <= SEQ_BIAS_DOWN;
					end
				end
				SEQ_BIAS_DOWN: begin
					if (seq_count == SEQ_LAST) begin
						seq_state <= SEQ_OFF;
					end else begin
						seq_count <= seq_count + 16'h0001;
					end
				end
				default: seq_state <= SEQ_OFF;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			panel_power_enable_o <= 1'b0;
			panel_bias_power_off <= 1'b1;
		end else begin
			panel_power_enable_o <= !power_down && seq_state != SEQ_OFF;
			panel_bias_power_off <= power_down || seq_state != SEQ_ON;
		end
	end

	assign bias_off_or_palette_write_o = panel_pin_function_register[PIN_FUNC_BIT]
		? palette_write_strobe_n : panel_bias_power_off;
	assign pixel_clock_o = pixel_clock;
	assign dac_enable_o = ~power_down;
endmodule
`default_nettype wire

// ===== core/panel_pins_pkg.sv
// Constants, register map and state types for the panel clock and power-down pin block.
package panel_pins_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;

	// Register offsets.
	localparam logic [3:0] CLK_SEL_ADDR = 4'h0;
	localparam logic [3:0] CLK_OPT_ADDR = 4'h1;
	localparam logic [3:0] PIN_FUNC_ADDR = 4'h2;
	localparam logic [3:0] MISC_CLK_ADDR = 4'h3;
	localparam logic [3:0] MODE_ADDR = 4'h4;
	localparam logic [3:0] FR_DIV_ADDR = 4'h5;
	localparam logic [3:0] PAL_STROBE_ADDR = 4'h6;
	localparam logic [3:0] STATUS_ADDR = 4'h7;

	// Field positions.
	localparam int unsigned SINGLE_SEL_BIT = 1;
	localparam int unsigned VSRC_LSB = 2;
	localparam int unsigned MCLK_SHIFT_BIT = 4;
	localparam int unsigned DUAL_SEL_BIT = 5;
	localparam int unsigned PANEL_ON_BIT = 0;
	localparam int unsigned PIN_FUNC_BIT = 2;
	localparam int unsigned SEL_LOW_BIT = 2;
	localparam int unsigned SEL_HIGH_BIT = 3;
	localparam int unsigned ST_EXT_MODE_BIT = 0;
	localparam int unsigned ST_POWER_DOWN_BIT = 1;
	localparam int unsigned ST_PANEL_EN_BIT = 2;
	localparam int unsigned ST_BIAS_ON_BIT = 3;

	// Reset values.
	localparam logic [7:0] CLK_SEL_RESET = 8'h00;
	localparam logic [7:0] CLK_OPT_RESET = 8'h00;
	localparam logic [7:0] PIN_FUNC_RESET = 8'h00;
	localparam logic [7:0] MISC_CLK_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] FR_DIV_RESET = 8'h0f;

	// Display mode codes held in the mode register.
	localparam logic [1:0] MODE_CRT = 2'h0;
	localparam logic [1:0] MODE_LCD = 2'h1;
	localparam logic [1:0] MODE_PLASMA = 2'h2;

	// Shift clock source codes in the clock select register.
	localparam logic [1:0] VSRC_PRIMARY = 2'h0;
	localparam logic [1:0] VSRC_SECOND = 2'h1;
	localparam logic [1:0] VSRC_THIRD = 2'h2;

	// Display geometry in pixels and lines.
	localparam logic [9:0] H_ACTIVE = 10'd640;
	localparam logic [9:0] H_TOTAL = 10'd800;
	localparam logic [9:0] V_ACTIVE = 10'd480;
	localparam logic [9:0] V_TOTAL = 10'd525;

	// Timing.
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned PANEL_SEQ_NS = 100000;
	localparam int unsigned LOAD_STROBE_NS = 100;
	localparam int unsigned PAL_STROBE_NS = 100;
	localparam int unsigned PANEL_SEQ_CYCLES = (PANEL_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LOAD_STROBE_CYCLES =
		(LOAD_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PAL_STROBE_CYCLES = (PAL_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {SEQ_OFF, SEQ_LOGIC, SEQ_ON, SEQ_BIAS_DOWN} seq_state_t;
endpackage

// ===== core/edge_if.sv
// Carrier for a synchronised pin level and its edge pulses.
`timescale 1ns/1ns
`default_nettype none
interface edge_if;
	logic level;
	logic rise;
	logic fall;
	modport source (output level, output rise, output fall);
	modport sink (input level, input rise, input fall);
endinterface
`default_nettype wire

// ===== core/pin_sync.sv
// Two-flop synchroniser with edge detection for one asynchronous pin.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
	parameter logic INIT = 1'b0
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic async_i,
	edge_if.source sync
);
	logic meta;
	logic stable;
	logic prev;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			meta <= INIT;
			stable <= INIT;
			prev <= INIT;
		end else begin
			meta <= async_i;
			stable <= meta;
			prev <= stable;
		end
	end

	assign sync.level = stable;
	assign sync.rise = stable & ~prev;
	assign sync.fall = ~stable & prev;
endmodule
`default_nettype wire

// ===== verification/panel_far_side.sv
// Far side of the pins: three video oscillators, the shared clock pins and a RAMDAC latch.
`timescale 1ns/1ns
`default_nettype none
module panel_far_side (
	input wire logic second_drv_i,
	input wire logic second_oe_n_i,
	input wire logic third_drv_i,
	input wire logic third_oe_n_i,
	input wire logic pixel_clock_i,
	input wire logic [7:0] pixel_i,
	output logic primary_o,
	output logic second_pin_o,
	output logic third_pin_o,
	output logic [7:0] latched_o
);
	logic osc2 = 1'b0;
	logic osc3 = 1'b0;
	initial begin
		primary_o = 1'b0;
		forever #200 primary_o = ~primary_o;
	end
	initial forever #150 osc2 = ~osc2;
	initial forever #250 osc3 = ~osc3;
	// An oscillator sits on a shared pin only while the block leaves the pin as an input.
	assign second_pin_o = second_oe_n_i ? osc2 : second_drv_i;
	assign third_pin_o = third_oe_n_i ? osc3 : third_drv_i;
	// Latching on the falling edge keeps half a pixel of margin after the data moved.
	always @(negedge pixel_clock_i) begin
		latched_o <= pixel_i;
	end
endmodule
`default_nettype wire

// ===== verification/panel_clock_pins_assertions.sv
// Port-level checker for clock pins, pixel stream and power-down behaviour.
`timescale 1ns/1ns
`default_nettype none
module panel_pins_checker
	import panel_pins_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic memory_data_bit3_strap_i,
	input wire logic second_video_clock_o,
	input wire logic second_video_clock_oe_n_o,
	input wire logic third_video_clock_o,
	input wire logic third_video_clock_oe_n_o,
	input wire logic power_down_in_n_i,
	input wire logic pixel_take_o,
	input wire logic panel_power_enable_o,
	input wire logic pixel_clock_o,
	input wire logic [3:0] upper_panel_data_o,
	input wire logic [3:0] lower_panel_data_o,
	input wire logic dac_enable_o
);
	// Shadow copies of the written control fields, rebuilt from the bus alone.
	logic sel1, dual, opt4, strap_q;
	logic [1:0] src, misc;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			strap_q <= memory_data_bit3_strap_i;
		end
	end
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sel1 <= 1'b0;
			src <= 2'h0;
			dual <= 1'b0;
			opt4 <= 1'b0;
			misc <= 2'h0;
		end else if (reg_write_i && reg_addr_i == CLK_SEL_ADDR) begin
			sel1 <= reg_wdata_i[SINGLE_SEL_BIT];
			src <= reg_wdata_i[VSRC_LSB +: 2];
		end else if (reg_write_i && reg_addr_i == CLK_OPT_ADDR) begin
			dual <= reg_wdata_i[DUAL_SEL_BIT];
			opt4 <= reg_wdata_i[MCLK_SHIFT_BIT];
		end else if (reg_write_i && reg_addr_i == MISC_CLK_ADDR) begin
			misc <= reg_wdata_i[SEL_HIGH_BIT:SEL_LOW_BIT];
		end
	end
	property p_strap;
		(second_video_clock_oe_n_o == !strap_q) && (third_video_clock_oe_n_o == !strap_q);
	endproperty
	a_strap: assert property (p_strap) else $error("clock pin direction differs from strap");
	property p_load;
		reg_write_i && reg_addr_i == MISC_CLK_ADDR && !dual && !second_video_clock_oe_n_o
			|=> second_video_clock_o [*2] ##1 !second_video_clock_o;
	endproperty
	a_load: assert property (p_load) else $error("load strobe not two cycles");
	property p_single;
		!third_video_clock_oe_n_o && !dual && !$past(reg_write_i) && !$past(reg_write_i, 2)
			|-> third_video_clock_o == sel1;
	endproperty
	a_single: assert property (p_single) else $error("single select pin wrong");
	property p_dual;
		!second_video_clock_oe_n_o && dual && !$past(reg_write_i) && !$past(reg_write_i, 2)
			|-> {third_video_clock_o, second_video_clock_o} == misc;
	endproperty
	a_dual: assert property (p_dual) else $error("dual select pins wrong");
	property p_mclk;
		(opt4 || (src == 2'h3 && second_video_clock_oe_n_o)) && !$past(reg_write_i)
			&& !$past(reg_write_i, 2)
			&& power_down_in_n_i && $past(power_down_in_n_i) && $past(power_down_in_n_i, 2)
			&& $past(power_down_in_n_i, 3) |-> pixel_clock_o != $past(pixel_clock_o);
	endproperty
	a_mclk: assert property (p_mclk) else $error("pixel clock idle on memory clock");
	property p_data;
		// Power-down clears the data with the pixel clock held low, so it is left out.
		($changed(upper_panel_data_o) || $changed(lower_panel_data_o)) && dac_enable_o
			|-> $rose(pixel_clock_o);
	endproperty
	a_data: assert property (p_data) else $error("pixel data moved off rising edge");
	property p_pd;
		!power_down_in_n_i [*5] |-> !panel_power_enable_o && !dac_enable_o
			&& !pixel_clock_o && !pixel_take_o;
	endproperty
	a_pd: assert property (p_pd) else $error("outputs live during power down");
	property p_sync;
		!power_down_in_n_i && $past(power_down_in_n_i) && $past(power_down_in_n_i, 2)
			&& $past(power_down_in_n_i, 3) |-> dac_enable_o;
	endproperty
	a_sync: assert property (p_sync) else $error("power down acted unsynchronised");
endmodule
bind panel_clock_pins panel_pins_checker checker_i (.clk_i, .reset_i, .reg_addr_i,
	.reg_wdata_i, .reg_write_i, .memory_data_bit3_strap_i, .second_video_clock_o,
	.second_video_clock_oe_n_o, .third_video_clock_o, .third_video_clock_oe_n_o,
	.power_down_in_n_i, .pixel_take_o, .panel_power_enable_o, .pixel_clock_o,
	.upper_panel_data_o, .lower_panel_data_o, .dac_enable_o);
`default_nettype wire

// ===== verification/panel_clock_pins_tb.sv
// Self-checking bench for the panel clock, panel interface and power-down pin block.
`timescale 1ns/1ns
`default_nettype none
module panel_clock_pins_tb;
	import panel_pins_pkg::*;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [3:0] reg_addr_i = 4'h0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_write_i = 1'b0;
	logic reg_read_i = 1'b0;
	logic memory_data_bit3_strap_i = 1'b0;
	logic power_down_in_n_i = 1'b1;
	logic [7:0] pixel_data_i = 8'ha5;
	logic [7:0] reg_rdata_o, latched, acc, pwr;
	logic [3:0] upper_panel_data_o, lower_panel_data_o;
	logic primary_video_clock_i, second_video_clock_i, third_video_clock_i;
	logic second_video_clock_o, second_video_clock_oe_n_o, third_video_clock_o;
	logic third_video_clock_oe_n_o, pixel_take_o, panel_power_enable_o, pixel_clock_o;
	logic bias_off_or_palette_write_o, frame_rate_or_blank_o, column_driver_shift_clock_o;
	logic gray_weight_clock_o, frame_start_pulse_o, line_latch_pulse_o, dac_enable_o;
	logic [5:0] strobes;
	logic [7:0] resets [9] = '{CLK_SEL_RESET, CLK_OPT_RESET, PIN_FUNC_RESET, MISC_CLK_RESET,
		MODE_RESET, FR_DIV_RESET, 8'h00, 8'h00, 8'h00};
	int failures = 0;
	int comparisons = 0;
	assign strobes = {column_driver_shift_clock_o, gray_weight_clock_o, frame_start_pulse_o,
		line_latch_pulse_o, frame_rate_or_blank_o, pixel_clock_o};
	assign pwr = {5'h0, dac_enable_o, panel_power_enable_o, bias_off_or_palette_write_o};
	initial forever #25 clk_i = ~clk_i;
	panel_clock_pins dut (.clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
		.reg_read_i, .reg_rdata_o, .memory_data_bit3_strap_i, .primary_video_clock_i,
		.second_video_clock_i, .second_video_clock_o, .second_video_clock_oe_n_o,
		.third_video_clock_i, .third_video_clock_o, .third_video_clock_oe_n_o,
		.power_down_in_n_i, .pixel_data_i, .pixel_take_o, .panel_power_enable_o,
		.bias_off_or_palette_write_o, .pixel_clock_o, .frame_rate_or_blank_o,
		.upper_panel_data_o, .lower_panel_data_o, .column_driver_shift_clock_o,
		.gray_weight_clock_o, .frame_start_pulse_o, .line_latch_pulse_o, .dac_enable_o);
	panel_far_side far_side (.second_drv_i(second_video_clock_o),
		.second_oe_n_i(second_video_clock_oe_n_o), .third_drv_i(third_video_clock_o),
		.third_oe_n_i(third_video_clock_oe_n_o), .pixel_clock_i(pixel_clock_o),
		.pixel_i({upper_panel_data_o, lower_panel_data_o}), .primary_o(primary_video_clock_i),
		.second_pin_o(second_video_clock_i), .third_pin_o(third_video_clock_i),
		.latched_o(latched));
	task automatic close_out();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
		comparisons++;
		if (seen !== want) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic do_reset(input logic strap);
		@(posedge clk_i);
		reset_i <= 1'b1;
		memory_data_bit3_strap_i <= strap;
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
		tick(1);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_write_i <= 1'b1;
		@(posedge clk_i);
		reg_write_i <= 1'b0;
		#1;
	endtask
	task automatic rdc(input string what, input logic [3:0] a, input logic [7:0] want);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_read_i <= 1'b1;
		@(posedge clk_i);
		reg_read_i <= 1'b0;
		#1;
		check(what, reg_rdata_o, want);
	endtask
	task automatic watch(input string what, input int n, input logic [5:0] care, want);
		logic [5:0] prev;
		logic [5:0] moved;
		prev = strobes;
		moved = 6'h00;
		repeat (n) begin
			tick(1);
			moved = moved | (strobes ^ prev);
			prev = strobes;
		end
		check(what, {2'h0, moved & care}, {2'h0, want});
	endtask
	// Needs the memory clock as shift source, so the pixel clock falls one cycle after a step.
	task automatic take_check(input string what, input logic [7:0] want);
		int n;
		n = 0;
		tick(1);
		while (pixel_take_o !== 1'b1 && n < 4000) begin
			tick(1);
			n++;
		end
		if (n == 4000) begin
			failures++;
			close_out();
		end
		tick(1);
		check(what, {upper_panel_data_o, lower_panel_data_o}, want);
		tick(1);
		check("ramdac latch", latched, want);
	endtask
	initial begin
		do_reset(1'b0);
		for (int i = 0; i < 9; i++) begin
			if (i != 6) begin
				rdc("reset value", 4'(i), resets[i]);
			end
		end
		check("pin enables", {6'h0, second_video_clock_oe_n_o, third_video_clock_oe_n_o},
			8'h03);
		wr(STATUS_ADDR, 8'hff);
		wr(4'h9, 8'hff);
		rdc("status read only", STATUS_ADDR, 8'h00);
		rdc("unmapped", 4'h9, 8'h00);
		$display("test registers done");
		wr(CLK_OPT_ADDR, 8'h10);
		wr(MODE_ADDR, {6'h0, MODE_LCD});
		watch("lcd strobes", 3400, 6'h3f, 6'h3f);
		take_check("lcd data", 8'ha5);
		wr(MODE_ADDR, {6'h0, MODE_PLASMA});
		watch("plasma strobes", 1700, 6'h37, 6'h17);
		take_check("plasma data", 8'ha0);
		wr(MODE_ADDR, {6'h0, MODE_CRT});
		watch("crt strobes", 1700, 6'h3f, 6'h03);
		take_check("crt data", 8'ha5);
		wr(CLK_OPT_ADDR, 8'h00);
		for (int s = 0; s < 4; s++) begin
			wr(CLK_SEL_ADDR, 8'(s << 2));
			watch("shift source", 200, 6'h01, 6'h01);
		end
		$display("test pixel stream done");
		wr(PIN_FUNC_ADDR, 8'h01);
		tick(2);
		check("enable on", pwr, 8'h07);
		tick(2005);
		check("bias on", pwr, 8'h06);
		rdc("status on", STATUS_ADDR, 8'h0c);
		wr(PIN_FUNC_ADDR, 8'h05);
		check("strobe idle", pwr, 8'h07);
		wr(PAL_STROBE_ADDR, 8'h00);
		acc = 8'h00;
		repeat (5) begin
			acc = acc + {7'h0, ~bias_off_or_palette_write_o};
			tick(1);
		end
		check("strobe width", acc, 8'h02);
		wr(PIN_FUNC_ADDR, 8'h00);
		tick(2);
		check("bias off first", pwr, 8'h07);
		tick(2005);
		check("enable off", pwr, 8'h05);
		$display("test panel power done");
		wr(PIN_FUNC_ADDR, 8'h01);
		@(posedge clk_i);
		power_down_in_n_i <= 1'b0;
		tick(6);
		check("powered down", pwr, 8'h01);
		check("blank", {7'h0, frame_rate_or_blank_o}, 8'h01);
		watch("halted", 100, 6'h3f, 6'h00);
		rdc("status down", STATUS_ADDR, 8'h02);
		wr(FR_DIV_ADDR, 8'h03);
		rdc("divider", FR_DIV_ADDR, 8'h03);
		@(posedge clk_i);
		power_down_in_n_i <= 1'b1;
		tick(6);
		check("dac back", {7'h0, dac_enable_o}, 8'h01);
		$display("test power down done");
		do_reset(1'b1);
		check("pin enables ext", {6'h0, second_video_clock_oe_n_o, third_video_clock_oe_n_o},
			8'h00);
		rdc("status ext", STATUS_ADDR, 8'h01);
		wr(CLK_SEL_ADDR, 8'h02);
		tick(2);
		check("single select", {7'h0, third_video_clock_o}, 8'h01);
		wr(MISC_CLK_ADDR, 8'h04);
		acc = 8'h00;
		repeat (5) begin
			acc = acc + {7'h0, second_video_clock_o};
			tick(1);
		end
		check("load strobe", acc, 8'h02);
		wr(CLK_OPT_ADDR, 8'h30);
		for (int v = 0; v < 4; v++) begin
			wr(MISC_CLK_ADDR, 8'(v << 2));
			tick(2);
			check("dual select", {6'h0, third_video_clock_o, second_video_clock_o},
				8'(v));
		end
		take_check("ext data", 8'ha5);
		$display("test external clock done");
		close_out();
	end
endmodule
`default_nettype wire
